// >>> hdl/hbms_top.sv
// Mode, power sequencing and protection control of the bridge driver
`timescale 1ns/1ps
`include "hbms_cfg.svh"
module hbms_top #(
  parameter int WAKE_CYC = (`HBMS_WAKE_MAX_NS * `HBMS_CLK_MHZ) / 1000,
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_enable_in,
  input wire logic output_disable_in,
  input wire logic direction_in_a,
  input wire logic direction_in_b,
  input wire logic power_rail_ok,
  input wire logic supplies_ready,
  input wire logic pump_voltage_ok,
  input wire logic short_current_in,
  input wire logic over_limit_in,
  input wire logic thermal_warn_in,
  input wire logic over_temp_in,
  input wire logic over_volt_in,
  input wire logic thermal_stress_in,
  output logic fault_flag_n,
  output logic bridge_out_a,
  output logic bridge_out_b,
  output logic bridge_oe_a,
  output logic bridge_oe_b,
  output logic regulator_en,
  output logic [2:0] slew_sel,
  output logic [1:0] ilim_sel,
  output logic chop_active,
  output hbms_pkg::hbms_mode_t mode
);
  import hbms_pkg::*;

  localparam int NSYNC = 13;
  localparam int PO_CYC = (`HBMS_PO_MIN_NS * `HBMS_CLK_MHZ + 999) / 1000;
  localparam int PO_MAX = (`HBMS_PO_MAX_NS * `HBMS_CLK_MHZ) / 1000;
  localparam int PD_CYC = (`HBMS_PD_MIN_NS * `HBMS_CLK_MHZ + 999) / 1000;
  localparam int PD_MAX = (`HBMS_PD_MAX_NS * `HBMS_CLK_MHZ) / 1000;
  localparam logic [9:0] CHOP_LEN = 10'(`HBMS_CHOP_CYC);
  localparam logic [31:0] CTRL_RST = `HBMS_CTRL_RST;

  generate
    if (WAKE_CYC < 2 || WAKE_CYC > 131071 || ADDR_W < 4)
    begin : g_bad
      $error("hbms_top: parameter out of range");
    end
  endgenerate

  // Every control pin and analog comparator is asynchronous to pclk
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] sync_s;
  assign raw = {thermal_stress_in, over_volt_in, over_temp_in,
                thermal_warn_in, over_limit_in, short_current_in,
                pump_voltage_ok, supplies_ready, power_rail_ok,
                direction_in_b, direction_in_a, output_disable_in,
                wake_enable_in};

  generate
    for (genvar i = 0; i < NSYNC; i++)
    begin : g_sync
      logic meta_q;
      logic sync_q;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else
        begin
          meta_q <= raw[i];
          sync_q <= meta_q;
        end
      end
      assign sync_s[i] = sync_q;
    end
  endgenerate

  logic en_s, dis_s, dir_a_s, dir_b_s, rail_s, sup_s, pump_s;
  logic oc_s, lim_s, tw_s, ot_s, ov_s, stress_s;
  assign {stress_s, ov_s, ot_s, tw_s, lim_s, oc_s, pump_s, sup_s,
          rail_s, dir_b_s, dir_a_s, dis_s, en_s} = sync_s;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  hbms_mode_t state_q;
  logic [16:0] tmr_q;
  logic en_p_q, dis_p_q;
  logic [4:0] status_q, present_v, clr_v;
  logic oe_q, sdir_a_q, sdir_b_q, half_q;
  logic [2:0] slew_q;
  logic [1:0] ilim_q;
  logic chop_q;
  logic [9:0] chop_cnt_q;
  logic awake, fault_any, drive_ok, wake_to, clr_evt;
  logic acc, wr_ctrl, wr_stat, mapped;
  logic [31:0] rd_v;

  assign awake = (state_q != hbms_sleep) && (state_q != hbms_pdown);
  assign fault_any = |(status_q & ~(5'h1 << `HBMS_ST_TW));
  assign drive_ok = oe_q && !dis_s && pump_s;
  assign wake_to = (state_q == hbms_wake) && !sup_s
                   && (tmr_q == 17'(WAKE_CYC - 1));
  assign clr_evt = (dis_p_q && !dis_s) || (!en_p_q && en_s);

  // Mode sequencing; one timer serves wake, pulse and power-down
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= hbms_sleep;
      tmr_q <= 17'h0;
    end
    else
    begin
      if (tmr_q != 17'h1ffff)
        tmr_q <= tmr_q + 17'h1;
      case (state_q)
        hbms_sleep:
          if (en_s && rail_s)
          begin
            state_q <= hbms_wake;
            tmr_q <= 17'h0;
          end
        hbms_wake:
          if (!en_s)
          begin
            state_q <= hbms_pdown;
            tmr_q <= 17'h0;
          end
          else if (sup_s)
          begin
            state_q <= hbms_pulse;
            tmr_q <= 17'h0;
          end
          else if (wake_to)
          begin
            state_q <= hbms_fault;
          end
        hbms_pulse:
          if (!en_s)
          begin
            state_q <= hbms_pdown;
            tmr_q <= 17'h0;
          end
          else if (tmr_q >= 17'(PO_CYC - 1) && pump_s)
          begin
            state_q <= hbms_standby;
          end
        hbms_standby, hbms_normal:
          if (!en_s)
          begin
            state_q <= hbms_pdown;
            tmr_q <= 17'h0;
          end
          else if (fault_any)
            state_q <= hbms_fault;
          else if (drive_ok)
            state_q <= hbms_normal;
          else
            state_q <= hbms_standby;
        hbms_fault:
          if (!en_s)
          begin
            state_q <= hbms_pdown;
            tmr_q <= 17'h0;
          end
          else if (!fault_any)
            state_q <= hbms_standby;
        hbms_pdown:
          if (tmr_q == 17'(PD_CYC - 1))
            state_q <= hbms_sleep;
        default:
          state_q <= hbms_sleep;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_p_q <= 1'b0;
      dis_p_q <= 1'b0;
    end
    else
    begin
      en_p_q <= en_s;
      dis_p_q <= dis_s;
    end
  end

  // Fault latches; a set in the clearing cycle wins over the clear
  always_comb
  begin
    present_v = 5'h0;
    present_v[`HBMS_ST_OT] = ot_s;
    present_v[`HBMS_ST_TW] = tw_s;
    present_v[`HBMS_ST_OC] = oc_s;
    present_v[`HBMS_ST_OV] = ov_s;
    present_v[`HBMS_ST_UV] = wake_to || (!pump_s &&
      (state_q == hbms_standby || state_q == hbms_normal));
    clr_v = {5{clr_evt}};
    if (wr_stat)
      clr_v = clr_v | pwdata[4:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_q <= 5'h0;
    else if (state_q == hbms_sleep)
      status_q <= 5'h0;
    else if (awake || state_q == hbms_wake)
      status_q <= (status_q & ~clr_v) | present_v;
  end

  // Fault flag, active low, held low through wake, pulse and power-down
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_flag_n <= 1'b0;
    else
      case (state_q)
        hbms_sleep:
          fault_flag_n <= !dis_s;
        hbms_standby, hbms_normal:
          fault_flag_n <= !dis_s && !fault_any;
        default:
          fault_flag_n <= 1'b0;
      endcase
  end

  // Chopping: stretching the off time lowers the PWM rate under stress
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chop_q <= 1'b0;
      chop_cnt_q <= 10'h0;
    end
    else if (state_q != hbms_normal)
    begin
      chop_q <= 1'b0;
      chop_cnt_q <= 10'h0;
    end
    else if (!chop_q)
    begin
      chop_q <= lim_s;
      chop_cnt_q <= 10'h0;
    end
    else if (chop_cnt_q >= (stress_s ? {CHOP_LEN[8:0], 1'b0} : CHOP_LEN)
             - 10'h1)
      chop_q <= 1'b0;
    else
      chop_cnt_q <= chop_cnt_q + 10'h1;
  end

  // Bridge drive; outputs off unless normal, brake only in fault
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bridge_out_a <= 1'b0;
      bridge_out_b <= 1'b0;
      bridge_oe_a <= 1'b0;
      bridge_oe_b <= 1'b0;
    end
    else if (oc_s || ot_s)
    begin
      bridge_out_a <= 1'b0;
      bridge_out_b <= 1'b0;
      bridge_oe_a <= 1'b0;
      bridge_oe_b <= 1'b0;
    end
    else if (state_q == hbms_normal && !chop_q && !dis_s)
    begin
      bridge_out_a <= dir_a_s | sdir_a_q;
      bridge_out_b <= dir_b_s | sdir_b_q;
      bridge_oe_a <= 1'b1;
      bridge_oe_b <= 1'b1;
    end
    else if (state_q == hbms_fault && ov_s && !half_q)
    begin
      bridge_out_a <= 1'b1;
      bridge_out_b <= 1'b1;
      bridge_oe_a <= 1'b1;
      bridge_oe_b <= 1'b1;
    end
    else
    begin
      bridge_out_a <= 1'b0;
      bridge_out_b <= 1'b0;
      bridge_oe_a <= 1'b0;
      bridge_oe_b <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      regulator_en <= 1'b0;
      chop_active <= 1'b0;
      mode <= hbms_sleep;
    end
    else
    begin
      regulator_en <= (state_q != hbms_sleep);
      chop_active <= chop_q;
      mode <= state_q;
    end
  end

  // APB slave; one wait state so that every output stays registered
  assign acc = psel && penable && pready;
  assign wr_ctrl = acc && pwrite && hit(paddr, `HBMS_CTRL_OFS);
  assign wr_stat = acc && pwrite && hit(paddr, `HBMS_STAT_OFS);

  always_comb
  begin
    rd_v = 32'h0;
    mapped = 1'b1;
    if (hit(paddr, `HBMS_CTRL_OFS))
    begin
      rd_v[`HBMS_CTRL_OE] = oe_q;
      rd_v[`HBMS_CTRL_DIRA] = sdir_a_q;
      rd_v[`HBMS_CTRL_DIRB] = sdir_b_q;
      rd_v[`HBMS_CTRL_HALF] = half_q;
      rd_v[`HBMS_CTRL_SLEW +: 3] = slew_q;
      rd_v[`HBMS_CTRL_ILIM +: 2] = ilim_q;
    end
    else if (hit(paddr, `HBMS_STAT_OFS))
      rd_v[4:0] = status_q;
    else if (hit(paddr, `HBMS_LIVE_OFS))
    begin
      rd_v[2:0] = state_q;
      rd_v[`HBMS_LIVE_FLAG] = fault_flag_n;
      rd_v[`HBMS_LIVE_CHOP] = chop_q;
      rd_v[`HBMS_LIVE_REG] = regulator_en;
    end
    else
      mapped = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= (psel && !pwrite) ? rd_v : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oe_q <= CTRL_RST[`HBMS_CTRL_OE];
      sdir_a_q <= CTRL_RST[`HBMS_CTRL_DIRA];
      sdir_b_q <= CTRL_RST[`HBMS_CTRL_DIRB];
      half_q <= CTRL_RST[`HBMS_CTRL_HALF];
      slew_q <= CTRL_RST[`HBMS_CTRL_SLEW +: 3];
      ilim_q <= CTRL_RST[`HBMS_CTRL_ILIM +: 2];
    end
    else if (wr_ctrl)
    begin
      oe_q <= pwdata[`HBMS_CTRL_OE];
      sdir_a_q <= pwdata[`HBMS_CTRL_DIRA];
      sdir_b_q <= pwdata[`HBMS_CTRL_DIRB];
      half_q <= pwdata[`HBMS_CTRL_HALF];
      slew_q <= pwdata[`HBMS_CTRL_SLEW +: 3];
      ilim_q <= pwdata[`HBMS_CTRL_ILIM +: 2];
    end
  end

  assign slew_sel = slew_q;
  assign ilim_sel = ilim_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sleep_regs_off: assert property (
    state_q == hbms_sleep && $past(state_q) == hbms_sleep
    |-> !regulator_en && !bridge_oe_a && !bridge_oe_b)
    else $error("sleep left something on");
  a_standby_hiz: assert property (
    $past(state_q) == hbms_standby && $past(presetn)
    |-> !bridge_oe_a && !bridge_oe_b)
    else $error("standby drives outputs");
  a_fault_entry: assert property (
    state_q != hbms_fault ##1 state_q == hbms_fault
    |=> !fault_flag_n [*2])
    else $error("fault flag not latched low");
  a_wake_start: assert property (
    state_q == hbms_sleep && en_s && rail_s |=> state_q == hbms_wake)
    else $error("wake not started");
  a_wake_bound: assert property (
    state_q == hbms_wake |-> tmr_q < 17'(WAKE_CYC))
    else $error("wake exceeds time limit");
  a_pulse_min: assert property (
    state_q == hbms_standby && $past(state_q) == hbms_pulse
    |-> $past(tmr_q) >= 17'(PO_CYC - 1) && $past(tmr_q) < 17'(PO_MAX))
    else $error("power-up pulse too short");
  a_pulse_release: assert property (
    state_q == hbms_pulse && pump_s && en_s && tmr_q == 17'(PO_CYC - 1)
    |=> state_q == hbms_standby)
    else $error("pulse not released");
  a_enable_drop: assert property (
    awake && state_q != hbms_wake && !en_s
    |=> state_q == hbms_pdown ##1 !fault_flag_n && !bridge_oe_a)
    else $error("enable drop not handled");
  a_pdown_length: assert property (
    state_q == hbms_sleep && $past(state_q) == hbms_pdown
    |-> $past(tmr_q) == 17'(PD_CYC - 1) && PD_CYC <= PD_MAX)
    else $error("power-down length wrong");
  a_flag_needs_dis: assert property (
    fault_flag_n |-> !$past(dis_s))
    else $error("flag high with disable high");
  a_pdown_flag: assert property (
    $past(state_q) == hbms_pdown && $past(presetn) |-> !fault_flag_n)
    else $error("flag released in power-down");
  a_short_off: assert property (
    oc_s || ot_s |=> !bridge_oe_a && !bridge_oe_b)
    else $error("outputs on during short or overtemp");
  a_chop_start: assert property (
    state_q == hbms_normal && lim_s && !chop_q && $stable(state_q)
    |=> chop_q ##1 !bridge_oe_a)
    else $error("chop not started");
  a_warn_latch: assert property (
    tw_s && awake |=> status_q[`HBMS_ST_TW])
    else $error("thermal warning not latched");
  a_ov_brake: assert property (
    state_q == hbms_fault && ov_s && !half_q && !oc_s && !ot_s
    |=> bridge_oe_a && bridge_out_a && bridge_out_b)
    else $error("overvoltage brake missing");
  a_set_wins: assert property (
    awake && present_v != 5'h0
    |=> (status_q & $past(present_v)) == $past(present_v))
    else $error("fault set lost");

  c_reach_normal: cover property (
    state_q == hbms_standby ##1 state_q == hbms_normal);
  c_fault_recover: cover property (
    state_q == hbms_fault ##1 state_q == hbms_standby);
  c_pdown_done: cover property (
    state_q == hbms_pdown ##1 state_q == hbms_sleep);
  c_chop_stress: cover property (chop_q && stress_s);
endmodule : hbms_top

// >>> inc/hbms_cfg.svh
// Constants of the bridge mode and fault sequencer
`ifndef HBMS_CFG_SVH
`define HBMS_CFG_SVH
`define HBMS_CLK_MHZ 125
`define HBMS_WAKE_MAX_NS 1000000
`define HBMS_PO_MIN_NS 1000
`define HBMS_PO_MAX_NS 2000
`define HBMS_PD_MIN_NS 8000
`define HBMS_PD_MAX_NS 11000
`define HBMS_CHOP_CYC 250
`define HBMS_CTRL_OFS 8'h00
`define HBMS_STAT_OFS 8'h04
`define HBMS_LIVE_OFS 8'h08
`define HBMS_CTRL_OE 0
`define HBMS_CTRL_DIRA 1
`define HBMS_CTRL_DIRB 2
`define HBMS_CTRL_HALF 3
`define HBMS_CTRL_SLEW 4
`define HBMS_CTRL_ILIM 8
`define HBMS_CTRL_RST 32'h0000_0131
`define HBMS_ST_OT 0
`define HBMS_ST_TW 1
`define HBMS_ST_OC 2
`define HBMS_ST_OV 3
`define HBMS_ST_UV 4
`define HBMS_LIVE_FLAG 4
`define HBMS_LIVE_CHOP 5
`define HBMS_LIVE_REG 6
`endif

// >>> inc/hbms_pkg.sv
// Types of the bridge mode and fault sequencer
package hbms_pkg;
  typedef enum logic [2:0] {
    hbms_sleep,
    hbms_wake,
    hbms_pulse,
    hbms_standby,
    hbms_normal,
    hbms_fault,
    hbms_pdown
  } hbms_mode_t;
endpackage : hbms_pkg

// >>> test/hbms_host.sv
// Host side APB master model of the bridge sequencer
`timescale 1ns/1ps
module hbms_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Request held until pready is seen; a hung slave is cut by the bench timer
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : hbms_host

// >>> test/hbridge_mode_fault_sequencer_tb_top.sv
// Self-checking testbench of the bridge mode and fault sequencer
`timescale 1ns/1ps
`include "hbms_cfg.svh"
module hbridge_mode_fault_sequencer_tb_top;
  import hbms_pkg::*;
  // Short wake timeout keeps the run brief
  localparam int WK = 200;
  typedef struct {logic [31:0] d; logic e;} hbms_exp_t;
  hbms_exp_t exp_q[$];
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, ctrl;
  logic en, dis, dia, dib, rail, sup, pump, sc, lim, tw, ot, ov, ts;
  logic flag_n, oa, ob, oea, oeb, reg_en, chop;
  logic [2:0] slew;
  logic [1:0] ilim;
  hbms_mode_t mode;
  int err_total, n_compared, cyc, t, n, k;
  hbms_top #(.WAKE_CYC(WK)) hbms_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_enable_in(en), .output_disable_in(dis), .direction_in_a(dia),
    .direction_in_b(dib), .power_rail_ok(rail), .supplies_ready(sup),
    .pump_voltage_ok(pump), .short_current_in(sc), .over_limit_in(lim),
    .thermal_warn_in(tw), .over_temp_in(ot), .over_volt_in(ov),
    .thermal_stress_in(ts), .fault_flag_n(flag_n), .bridge_out_a(oa),
    .bridge_out_b(ob), .bridge_oe_a(oea), .bridge_oe_b(oeb),
    .regulator_en(reg_en), .slew_sel(slew), .ilim_sel(ilim),
    .chop_active(chop), .mode(mode));
  hbms_host hbms_host_inst (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic summarize();
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      err_total++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] e, input logic er);
    exp_q.push_back('{e, er});
    hbms_host_inst.xfer(w, a, d, rd);
  endtask : bus
  // Answer cycles are judged against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      hbms_exp_t x;
      x = exp_q.pop_front();
      if (!pwrite)
        chk("prdata", x.d, prdata);
      chk("pslverr", x.e, pslverr);
    end
  task automatic wait_for(input hbms_mode_t m, input int lim_c);
    for (int i = 0; i < lim_c && mode !== m; i++)
      @(negedge pclk);
    chk("mode", m, mode);
  endtask : wait_for
  task automatic bring_up(input int pd);
    int i;
    @(posedge pclk);
    pump <= (pd == 0);
    en <= 1'b1;
    t = cyc;
    wait_for(hbms_wake, 8);
    chk("reg_en", 1, reg_en);
    wait_for(hbms_pulse, 8);
    n = 0;
    while (mode === hbms_pulse && n < 400)
    begin
      if (flag_n !== 1'b0)
        chk("pulse_flag", 0, flag_n);
      if (n == pd && pd != 0)
      begin
        @(posedge pclk);
        pump <= 1'b1;
      end
      n++;
      @(negedge pclk);
    end
    if (pd == 0)
      chk("pulse_len", 1, n >= 125 && n <= 250);
    else
      chk("pump_hold", 1, n > pd);
    for (i = 0; i < 10 && flag_n !== 1'b1; i++)
      @(negedge pclk);
    chk("flag_up", 1, flag_n);
    chk("wake_time", 1, cyc - t <= WK);
  endtask : bring_up
  task automatic power_down();
    int i;
    @(posedge pclk);
    en <= 1'b0;
    t = cyc;
    for (i = 0; i < 6 && {oea, oeb, flag_n} !== 3'b000; i++)
      @(negedge pclk);
    chk("off", 0, {oea, oeb, flag_n});
    // From fault the outputs are already off, so this wait starts early
    wait_for(hbms_pdown, 8);
    while (flag_n === 1'b0 && cyc - t < 2000)
      @(negedge pclk);
    chk("pd_time", 1, cyc - t >= 1000 && cyc - t <= 1375);
    chk("sleep", {hbms_sleep, 1'b0}, {mode, reg_en});
    bus(0, `HBMS_STAT_OFS, 0, 0, 0);
  endtask : power_down
  initial
  begin
    presetn = 1'b0;
    {en, dis, dia, dib, pump, sc, lim, tw, ot, ov, ts} = 11'h0;
    rail = 1'b1;
    sup = 1'b1;
    k = $urandom(63);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    bus(0, `HBMS_CTRL_OFS, 0, `HBMS_CTRL_RST, 0);
    chk("defaults", {3'd3, 2'd1}, {slew, ilim});
    chk("sleep_off", 0, {reg_en, oea, oeb});
    bus(0, 8'h0c, 0, 0, 1);
    for (k = 0; k < 8; k++)
    begin
      ctrl = {22'h0, k[1:0], 1'b0, k[2:0], 4'h0};
      bus(1, `HBMS_CTRL_OFS, ctrl, 0, 0);
      bus(0, `HBMS_CTRL_OFS, 0, ctrl, 0);
      chk("sel", {k[2:0], k[1:0]}, {slew, ilim});
    end
    bring_up(150);
    wait_for(hbms_standby, 4);
    chk("standby_oe", 0, {oea, oeb});
    ctrl = {22'h0, 2'($urandom), 1'b0, 3'($urandom), 4'h1};
    bus(1, `HBMS_CTRL_OFS, ctrl, 0, 0);
    wait_for(hbms_normal, 8);
    bus(0, `HBMS_LIVE_OFS, 0, 32'h54, 0);
    bus(1, `HBMS_LIVE_OFS, 0, 0, 0);
    chk("sel_rand", {ctrl[6:4], ctrl[9:8]}, {slew, ilim});
    for (k = 0; k < 8; k++)
    begin
      ctrl[2:1] = {k[2], k[2]};
      bus(1, `HBMS_CTRL_OFS, ctrl, 0, 0);
      dia <= k[0];
      dib <= k[1];
      repeat (6) @(negedge pclk);
      chk("outs", {2'b11, k[0] | k[2], k[1] | k[2]}, {oea, oeb, oa, ob});
    end
    ctrl[2:1] = 2'b00;
    bus(1, `HBMS_CTRL_OFS, ctrl, 0, 0);
    @(posedge pclk);
    dis <= 1'b1;
    repeat (6) @(negedge pclk);
    chk("dis_high", 0, {oea, oeb, flag_n});
    @(posedge pclk);
    dis <= 1'b0;
    repeat (8) @(negedge pclk);
    chk("dis_low", 3'b111, {oea, oeb, flag_n});
    // Chop with and without thermal stress
    for (k = 0; k < 2; k++)
    begin
      @(posedge pclk);
      ts <= k[0];
      lim <= 1'b1;
      for (n = 0; n < 8 && chop !== 1'b1; n++)
        @(negedge pclk);
      @(posedge pclk);
      lim <= 1'b0;
      @(negedge pclk);
      for (n = 0; n < 1200 && chop === 1'b1; n++)
      begin
        if (n == 100)
          chk("chop_off", 0, oa & oea);
        @(negedge pclk);
      end
      chk("chop_len", 1, n >= 248 * (k + 1) && n <= 251 * (k + 1));
    end
    @(posedge pclk);
    ts <= 1'b0;
    tw <= 1'b1;
    repeat (6) @(posedge pclk);
    tw <= 1'b0;
    repeat (4) @(posedge pclk);
    bus(0, `HBMS_STAT_OFS, 0, 32'h2, 0);
    chk("warn_flag", 1, flag_n);
    bus(1, `HBMS_STAT_OFS, 32'h2, 0, 0);
    bus(0, `HBMS_STAT_OFS, 0, 0, 0);
    for (k = 0; k < 3; k++)
    begin
      if (k > 0)
      begin
        bring_up(0);
        wait_for(hbms_normal, 8);
      end
      @(posedge pclk);
      {ov, sc, ot} <= 3'b100 >> k;
      wait_for(hbms_fault, 8);
      chk("fault_flag", 0, flag_n);
      chk("oe_fault", k == 0 ? 2'b11 : 2'b00, {oea, oeb});
      if (k == 0)
      begin
        chk("brake", 2'b11, {oa, ob});
        // Half-bridge mode must not brake on overvoltage
        bus(1, `HBMS_CTRL_OFS, ctrl | 32'h8, 0, 0);
        repeat (2) @(negedge pclk);
        chk("half_no_brake", 2'b00, {oea, oeb});
        bus(1, `HBMS_CTRL_OFS, ctrl, 0, 0);
      end
      bus(0, `HBMS_STAT_OFS, 0, k == 2 ? 32'h1 : 32'h8 >> k, 0);
      if (k == 2)
      begin
        bus(1, `HBMS_STAT_OFS, 32'h1, 0, 0);
        bus(0, `HBMS_STAT_OFS, 0, 32'h1, 0);
      end
      @(posedge pclk);
      {ov, sc, ot} <= 3'b000;
      if (k == 1)
      begin
        repeat (4) @(posedge pclk);
        dis <= 1'b1;
        repeat (4) @(posedge pclk);
        dis <= 1'b0;
        repeat (6) @(posedge pclk);
        bus(0, `HBMS_STAT_OFS, 0, 0, 0);
      end
      power_down();
    end
    // Rail low blocks wake; supplies that never rise end in a timeout fault
    @(posedge pclk);
    rail <= 1'b0;
    sup <= 1'b0;
    en <= 1'b1;
    repeat (8) @(negedge pclk);
    chk("rail_low", {hbms_sleep, 1'b0}, {mode, reg_en});
    @(posedge pclk);
    rail <= 1'b1;
    wait_for(hbms_wake, 8);
    wait_for(hbms_fault, WK + 8);
    chk("to_flag", 0, flag_n);
    bus(0, `HBMS_STAT_OFS, 0, 32'h10, 0);
    @(posedge pclk);
    sup <= 1'b1;
    power_down();
    summarize();
  end
endmodule : hbridge_mode_fault_sequencer_tb_top
